// ==== verilog/adc_link_pkg.sv ====
// shared constants for the converter serial link, both ends and the host register map
package adc_link_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // conversion word and frame layout
    localparam int RESULT_W = 12;
    localparam int POS_W = 6;
    localparam int LEAD_ZEROS = 7;
    localparam int FRAME_BITS_MAX = 40;
    localparam int TX_START_POS = FRAME_BITS_MAX - 1 - LEAD_ZEROS;
    localparam int TX_MODE_POS = TX_START_POS - 1;
    localparam int TX_CHAN_POS = TX_START_POS - 2;
    localparam int TX_ORDER_POS = TX_START_POS - 3;
    localparam logic [POS_W-1:0] FRAME_SHORT = 6'h18;
    localparam logic [POS_W-1:0] FRAME_LONG = 6'h28;
    localparam int REP_TAIL = 16;

    // rising-edge index after the start bit (start bit edge is index 0)
    localparam logic [POS_W-1:0] POS_MODE = 6'h01;
    localparam logic [POS_W-1:0] POS_CHAN = 6'h02;
    localparam logic [POS_W-1:0] POS_ORDER = 6'h03;
    localparam logic [POS_W-1:0] POS_MSB = 6'h04;
    localparam logic [POS_W-1:0] POS_LSB = 6'h0F;
    localparam logic [POS_W-1:0] POS_REP_LAST = 6'h1A;
    localparam logic [POS_W-1:0] POS_MAX = 6'h3F;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int ACLK_PERIOD_NS = 50;
    localparam int CONV_HOLD_NS = 1200000;
    localparam int CONV_HOLD_CYCLES = CONV_HOLD_NS / ACLK_PERIOD_NS;
    localparam int SYNC_MIN_HALF = 3;
    localparam int DIV_W = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // host register map
    localparam int AXI_ADDR_W = 4;
    localparam int AXI_DATA_W = 32;
    localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [AXI_ADDR_W-1:0] REG_RESULT = 4'h8;
    localparam logic [AXI_ADDR_W-1:0] REG_ECHO = 4'hC;
    localparam int CTRL_START = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_CHAN = 2;
    localparam int CTRL_NOREP = 3;
    localparam int CTRL_IDLE_HIGH = 4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_MISMATCH = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // state encodings
    typedef enum logic [1:0] {
        DEV_WAIT = 2'b01,
        DEV_RUN = 2'b10
    } dev_phase_e;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_SETUP = 4'b0010,
        H_RUN = 4'b0100,
        H_GAP = 4'b1000
    } host_phase_e;

endpackage : adc_link_pkg

// ==== verilog/adc_spi_if.sv ====
// serial link between the converter end and the host end
`timescale 1ns/1ps
`default_nettype none

interface adc_spi_if;
    logic chip_select_shutdown_n;
    logic sclk;
    logic sdi;
    logic sdo_out;
    logic sdo_oe;
    wire sdo;

    // released pin shows the inverse of the held level, so a floating bit never reads as data
    assign sdo = sdo_oe ? sdo_out : ~sdo_out;

    modport host (
        output chip_select_shutdown_n,
        output sclk,
        output sdi,
        input sdo
    );

    modport device (
        input chip_select_shutdown_n,
        input sclk,
        input sdi,
        output sdo_out,
        output sdo_oe
    );
endinterface : adc_spi_if

`default_nettype wire

// ==== verilog/adc_sdo_launch.sv ====
// falling-edge launch stage for the converter serial output
`timescale 1ns/1ps
`default_nettype none

module adc_sdo_launch (
    // link clock and frame
    input wire logic sclk,
    input wire logic chip_select_shutdown_n,
    // values prepared on the rising edge
    input wire logic bit_d,
    input wire logic oe_d,
    input wire logic tail_d,
    // pin drive and sampling tail
    output logic sdo_out,
    output logic sdo_oe,
    output logic sample_tail
);
    import adc_link_pkg::*;

    typedef struct packed {
        logic bit_v;
        logic oe;
        logic tail;
    } launch_s;

    launch_s s_q;
    launch_s s_d;

    always_comb
    begin
        s_d.bit_v = bit_d;
        s_d.oe = oe_d;
        s_d.tail = tail_d;
    end

    // chip select high releases the pin without any clock edge
    always_ff @(negedge sclk or posedge chip_select_shutdown_n)
    begin
        if (chip_select_shutdown_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign sdo_out = s_q.bit_v;
    assign sdo_oe = s_q.oe;
    assign sample_tail = s_q.tail;

endmodule : adc_sdo_launch

`default_nettype wire

// ==== verilog/adc_spi_device.sv ====
// converter end of the serial link: command decode, sampling window, result shift-out
`timescale 1ns/1ps
`default_nettype none

module adc_spi_device (
    // link
    adc_spi_if.device link,
    // analog side
    input wire logic [adc_link_pkg::RESULT_W-1:0] conv_code,
    output logic sampling,
    // decoded command
    output logic input_mode_select,
    output logic channel_select,
    output logic lsb_repeat_disable
);
    import adc_link_pkg::*;

    typedef struct packed {
        dev_phase_e phase;
        logic [POS_W-1:0] pos;
        logic mode;
        logic chan;
        logic norep;
        logic [RESULT_W-1:0] code_s1;
        logic [RESULT_W-1:0] code_s2;
        logic [RESULT_W-1:0] code;
    } dev_s;

    dev_s s_q;
    dev_s s_d;
    logic [POS_W-1:0] pos_n;
    logic bit_d;
    logic oe_d;
    logic tail_d;
    logic sample_tail;
    logic [3:0] idx;

    ////////////////////////////////////////////////////////////////////////////////
    // rising-edge state: only edges are counted, never time
    always_comb
    begin
        s_d = s_q;
        pos_n = (s_q.pos == POS_MAX) ? s_q.pos : POS_W'(s_q.pos + 1'b1);
        s_d.code_s1 = conv_code;
        s_d.code_s2 = s_q.code_s1;
        unique case (s_q.phase)
            DEV_WAIT:
            begin
                if (link.sdi)
                begin
                    s_d.phase = DEV_RUN;
                    s_d.pos = '0;
                end
            end
            DEV_RUN:
            begin
                s_d.pos = pos_n;
                if (pos_n == POS_MODE)
                    s_d.mode = link.sdi;
                if (pos_n == POS_CHAN)
                    s_d.chan = link.sdi;
                if (pos_n == POS_ORDER)
                begin
                    s_d.norep = link.sdi;
                    s_d.code = s_q.code_s2;
                end
            end
        endcase
    end

    // chip select high ends the conversion even with the clock stopped
    always_ff @(posedge link.sclk or posedge link.chip_select_shutdown_n)
    begin
        if (link.chip_select_shutdown_n)
            s_q <= '{phase: DEV_WAIT, default: '0};
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next bit for the coming falling edge
    always_comb
    begin
        bit_d = 1'b0;
        idx = '0;
        oe_d = (s_q.phase == DEV_RUN) && (s_q.pos >= POS_ORDER);
        tail_d = (s_q.phase == DEV_RUN) && (s_q.pos == POS_CHAN);
        if (s_q.phase == DEV_RUN)
        begin
            if (s_q.pos >= POS_MSB && s_q.pos <= POS_LSB)
            begin
                idx = 4'(POS_LSB - s_q.pos);
                bit_d = s_q.code[idx];
            end
            else if (!s_q.norep && s_q.pos > POS_LSB && s_q.pos <= POS_REP_LAST)
            begin
                idx = 4'(s_q.pos - POS_LSB);
                bit_d = s_q.code[idx];
            end
        end
    end

    // data changes only on falling edges or when chip select rises, whatever the idle level
    adc_sdo_launch launch (
        .sclk(link.sclk),
        .chip_select_shutdown_n(link.chip_select_shutdown_n),
        .bit_d(bit_d),
        .oe_d(oe_d),
        .tail_d(tail_d),
        .sdo_out(link.sdo_out),
        .sdo_oe(link.sdo_oe),
        .sample_tail(sample_tail)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // window from second rising edge to the falling edge after the third rising edge
    assign sampling = (s_q.phase == DEV_RUN && s_q.pos == POS_CHAN) || sample_tail;
    assign input_mode_select = s_q.mode;
    assign channel_select = s_q.chan;
    assign lsb_repeat_disable = s_q.norep;

endmodule : adc_spi_device

`default_nettype wire

// ==== verilog/adc_spi_host.sv ====
// host end: register slave on the system bus and serial frame engine for the converter
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module adc_spi_host #(
    parameter int HALF_DIV = 4,
    parameter int CONV_HOLD_CYCLES = adc_link_pkg::CONV_HOLD_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic [adc_link_pkg::AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [adc_link_pkg::AXI_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read
    input wire logic [adc_link_pkg::AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [adc_link_pkg::AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // link
    adc_spi_if.host link
);
    import adc_link_pkg::*;

    // slow enough for the output sync, fast enough for the hold limit
    localparam int MAX_HALF = CONV_HOLD_CYCLES / (2 * (RESULT_W + 1));
    localparam int HALF_LIM = (HALF_DIV > MAX_HALF) ? MAX_HALF : HALF_DIV;
    localparam int HALF_EFF = (HALF_LIM < SYNC_MIN_HALF) ? SYNC_MIN_HALF : HALF_LIM;
    localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_EFF - 1);

    typedef struct packed {
        logic aw_have;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic w_have;
        logic [AXI_DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [AXI_DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic mode;
        logic chan;
        logic norep;
        logic idle_high;
        logic done;
        logic mismatch;
        logic [RESULT_W-1:0] result;
        logic [RESULT_W-1:0] echo;
        host_phase_e phase;
        logic cs_n;
        logic sclk;
        logic [DIV_W-1:0] div;
        logic [POS_W-1:0] bitcnt;
        logic [POS_W-1:0] frame_len;
        logic [FRAME_BITS_MAX-1:0] tx;
        logic [FRAME_BITS_MAX-1:0] rx;
        logic sdo_s1;
        logic sdo_s2;
    } host_s;

    host_s s_q;
    host_s s_d;
    logic [RESULT_W-1:0] echo_w;
    logic [RESULT_W-1:0] res_w;
    logic busy;

    function automatic logic hit(input logic [AXI_ADDR_W-1:0] a, input logic [AXI_ADDR_W-1:0] o);
        hit = (a == o);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////////
    // lsb-first repeat, bit i sits REP_TAIL-i places up in the capture
    generate
        for (genvar gi = 0; gi < RESULT_W; gi++)
        begin : g_echo
            assign echo_w[gi] = s_q.rx[REP_TAIL-gi];
        end
    endgenerate

    assign res_w = s_q.norep ? s_q.rx[RESULT_W-1:0] : s_q.rx[REP_TAIL+RESULT_W-1:REP_TAIL];
    assign busy = (s_q.phase != H_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_d = s_q;
        s_d.sdo_s1 = link.sdo;
        s_d.sdo_s2 = s_q.sdo_s1;

        // bus side
        if (s_q.bvalid && bready)
            s_d.bvalid = 1'b0;
        if (s_q.rvalid && rready)
            s_d.rvalid = 1'b0;
        if (awvalid && awready)
        begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = awaddr;
        end
        if (wvalid && wready)
        begin
            s_d.w_have = 1'b1;
            s_d.wdata = wdata;
            s_d.wstrb = wstrb;
        end
        if (arvalid && arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = '0;
            if (hit(araddr, REG_CTRL))
            begin
                s_d.rdata[CTRL_MODE] = s_q.mode;
                s_d.rdata[CTRL_CHAN] = s_q.chan;
                s_d.rdata[CTRL_NOREP] = s_q.norep;
                s_d.rdata[CTRL_IDLE_HIGH] = s_q.idle_high;
            end
            else if (hit(araddr, REG_STATUS))
            begin
                s_d.rdata[STAT_BUSY] = busy;
                s_d.rdata[STAT_DONE] = s_q.done;
                s_d.rdata[STAT_MISMATCH] = s_q.mismatch;
            end
            else if (hit(araddr, REG_RESULT))
                s_d.rdata[RESULT_W-1:0] = s_q.result;
            else if (hit(araddr, REG_ECHO))
                s_d.rdata[RESULT_W-1:0] = s_q.echo;
            else
                s_d.rresp = RESP_SLVERR;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
        begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            if (hit(s_q.awaddr, REG_CTRL))
            begin
                // configuration frozen while a frame runs
                if (!busy && s_q.wstrb[0])
                begin
                    s_d.mode = s_q.wdata[CTRL_MODE];
                    s_d.chan = s_q.wdata[CTRL_CHAN];
                    s_d.norep = s_q.wdata[CTRL_NOREP];
                    s_d.idle_high = s_q.wdata[CTRL_IDLE_HIGH];
                    s_d.sclk = s_q.wdata[CTRL_IDLE_HIGH];
                    if (s_q.wdata[CTRL_START])
                    begin
                        s_d.phase = H_SETUP;
                        s_d.div = '0;
                        s_d.bitcnt = '0;
                        s_d.rx = '0;
                        s_d.frame_len = s_q.wdata[CTRL_NOREP] ? FRAME_SHORT : FRAME_LONG;
                        s_d.tx = '0;
                        s_d.tx[TX_START_POS] = 1'b1;
                        s_d.tx[TX_MODE_POS] = s_q.wdata[CTRL_MODE];
                        s_d.tx[TX_CHAN_POS] = s_q.wdata[CTRL_CHAN];
                        s_d.tx[TX_ORDER_POS] = s_q.wdata[CTRL_NOREP];
                    end
                end
            end
            else if (hit(s_q.awaddr, REG_STATUS))
            begin
                if (s_q.wstrb[0] && s_q.wdata[STAT_DONE])
                    s_d.done = 1'b0;
                if (s_q.wstrb[0] && s_q.wdata[STAT_MISMATCH])
                    s_d.mismatch = 1'b0;
            end
            else if (!hit(s_q.awaddr, REG_RESULT) && !hit(s_q.awaddr, REG_ECHO))
                s_d.bresp = RESP_SLVERR;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // frame engine; set of done comes after the clear so it wins
        unique case (s_q.phase)
            H_IDLE: ;
            H_SETUP:
            begin
                s_d.cs_n = 1'b0; // select falls a cycle after the idle level settles
                s_d.div = (s_q.div == HALF_LAST) ? '0 : DIV_W'(s_q.div + 1'b1);
                if (s_q.div == HALF_LAST)
                    s_d.phase = H_RUN;
            end
            H_RUN:
            begin
                s_d.div = (s_q.div == HALF_LAST) ? '0 : DIV_W'(s_q.div + 1'b1);
                if (s_q.div == HALF_LAST)
                begin
                    s_d.sclk = !s_q.sclk;
                    if (!s_q.sclk)
                    begin
                        s_d.rx = {s_q.rx[FRAME_BITS_MAX-2:0], s_q.sdo_s2};
                        s_d.bitcnt = POS_W'(s_q.bitcnt + 1'b1);
                    end
                    else if (s_q.bitcnt != '0)
                        s_d.tx = {s_q.tx[FRAME_BITS_MAX-2:0], 1'b0};
                    if (s_d.bitcnt == s_q.frame_len && s_d.sclk == s_q.idle_high)
                        s_d.phase = H_GAP;
                end
            end
            H_GAP:
            begin
                s_d.div = (s_q.div == HALF_LAST) ? '0 : DIV_W'(s_q.div + 1'b1);
                if (s_q.div == HALF_LAST)
                begin
                    if (!s_q.cs_n)
                    begin
                        s_d.cs_n = 1'b1;
                        s_d.result = res_w;
                        s_d.echo = s_q.norep ? '0 : echo_w;
                        s_d.done = 1'b1;
                        if (!s_q.norep && echo_w != res_w)
                            s_d.mismatch = 1'b1;
                    end
                    else
                        s_d.phase = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '{phase: H_IDLE, cs_n: 1'b1, default: '0};
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign awready = !s_q.aw_have && !s_q.bvalid;
    assign wready = !s_q.w_have && !s_q.bvalid;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = !s_q.rvalid;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;
    assign link.chip_select_shutdown_n = s_q.cs_n;
    assign link.sclk = s_q.sclk;
    assign link.sdi = s_q.tx[FRAME_BITS_MAX-1];

endmodule : adc_spi_host

`default_nettype wire

// ==== verification/adc_spi_link_asserts.sv ====
// link protocol assertions for the converter serial link
`timescale 1ns/1ps
`default_nettype none

module adc_spi_link_asserts (
    // host clock
    input wire logic aclk,
    input wire logic aresetn,
    // link
    input wire logic chip_select_shutdown_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe
);
    import adc_link_pkg::*;
    logic [5:0] rise_q;
    logic idle_q;

    ////////////////////////////////////////////////////////////////////////////////
    // cleared by frame select only, just as the converter is
    always_ff @(posedge sclk or posedge chip_select_shutdown_n)
    begin
        if (chip_select_shutdown_n)
            rise_q <= 6'h00;
        else if (rise_q != 6'h3F)
            rise_q <= rise_q + 6'h01;
    end

    // idle level taken when the frame opens, compared when it closes
    always_ff @(posedge aclk)
    begin
        if ($fell(chip_select_shutdown_n))
            idle_q <= sclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_lead_zeros: assert property (
        @(posedge sclk) disable iff (chip_select_shutdown_n) rise_q < 6'h07 |-> !sdi
    ) else $error("data in high before start slot");
    a_start_slot: assert property (
        @(posedge sclk) disable iff (chip_select_shutdown_n) rise_q == 6'h07 |-> sdi
    ) else $error("start bit missing on clock eight");
    a_float_early: assert property (
        @(posedge sclk) disable iff (chip_select_shutdown_n) rise_q < 6'h0B |-> !sdo_oe
    ) else $error("output driven before null bit");
    a_null_low: assert property (
        @(posedge sclk) disable iff (chip_select_shutdown_n) rise_q == 6'h0B |-> sdo_oe && !sdo_out
    ) else $error("null bit not driven low");
    a_result_driven: assert property (
        @(posedge sclk) disable iff (chip_select_shutdown_n)
        rise_q > 6'h0B && rise_q < 6'h18 |-> sdo_oe
    ) else $error("output released during result");
    a_frame_count: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(chip_select_shutdown_n) |-> $past(rise_q) == FRAME_SHORT || $past(rise_q) == FRAME_LONG
    ) else $error("wrong clock count in frame");
    a_idle_level: assert property (
        @(posedge aclk) disable iff (!aresetn) $rose(chip_select_shutdown_n) |-> sclk == idle_q
    ) else $error("clock idle level changed across frame");
    a_out_steady: assert property (
        @(posedge aclk) disable iff (!aresetn || chip_select_shutdown_n)
        sclk && $past(sclk) |-> $stable(sdo_out)
    ) else $error("data out changed while clock high");
    a_in_steady: assert property (
        @(posedge aclk) disable iff (!aresetn || chip_select_shutdown_n)
        sclk && $past(sclk) |-> $stable(sdi)
    ) else $error("data in changed while clock high");
endmodule : adc_spi_link_asserts

`default_nettype wire

// ==== verification/adc_spi_byte_readout_bench.sv ====
// self-checking bench: host and converter ends joined over the serial link
`timescale 1ns/1ps
`default_nettype none

module adc_spi_byte_readout_bench;
    import adc_link_pkg::*;
    localparam int HALF = 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [11:0] conv_code = 12'h000;
    logic sampling, input_mode_select, channel_select, lsb_repeat_disable;
    int err_total = 0, checks = 0, cyc = 0, samp_cnt = 0;
    // {idle high, no repeat, channel, mode}
    logic [3:0] cfg [4] = '{4'h5, 4'hA, 4'h3, 4'hC};
    logic [11:0] code [4] = '{12'hA5C, 12'h3F1, 12'hFFF, 12'h001};

    adc_spi_if link ();
    adc_spi_host #(.HALF_DIV(HALF), .CONV_HOLD_CYCLES(260)) i_adc_spi_host (.aclk(aclk),
        .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(link));
    adc_spi_device i_adc_spi_device (.link(link), .conv_code(conv_code), .sampling(sampling),
        .input_mode_select(input_mode_select), .channel_select(channel_select),
        .lsb_repeat_disable(lsb_repeat_disable));
    adc_spi_link_asserts i_adc_spi_link_asserts (.aclk(aclk), .aresetn(aresetn),
        .chip_select_shutdown_n(link.chip_select_shutdown_n), .sclk(link.sclk),
        .sdi(link.sdi), .sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #25 aclk = ~aclk;
    end

    // sampling span measured in host cycles
    always @(posedge aclk)
    begin
        cyc++;
        if (sampling === 1'b1)
            samp_cnt++;
        if (cyc == 20000)
        begin
            err_total++;
            $display("ERROR %0t: timeout", $time);
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    ////////////////////////////////////////////////////////////////////////////////
    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (awvalid && !awready || wvalid && !wready);
        while (bvalid !== 1'b1)
            @(posedge aclk);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er}, "write response");
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
            @(posedge aclk);
        while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1)
            @(posedge aclk);
        d = rdata;
        rready <= 1'b0;
        check({30'h0, rresp}, {30'h0, er}, "read response");
    endtask : axi_read

    task automatic expect_rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        axi_read(a, d, RESP_OKAY);
        check(d, exp, what);
    endtask : expect_rd

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] d;
        logic [31:0] c;
        int s0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        expect_rd(REG_STATUS, 32'h0, "status at reset");
        expect_rd(REG_RESULT, 32'h0, "result at reset");
        axi_write(4'h2, 32'h1, RESP_SLVERR);
        axi_read(4'h6, d, RESP_SLVERR);
        check(d, 32'h0, "unmapped read data");
        $display("test reset and unmapped done");
        for (int k = 0; k < 4; k++)
        begin
            @(posedge aclk);
            conv_code <= code[k];
            s0 = samp_cnt;
            c = {27'h0, cfg[k], 1'b1};
            axi_write(REG_CTRL, c, RESP_OKAY);
            axi_write(REG_CTRL, ~c | 32'h1, RESP_OKAY);
            while (link.sdo_oe !== 1'b1)
                @(posedge aclk);
            check({31'h0, link.sdo}, 32'h0, "null bit");
            check({29'h0, input_mode_select, channel_select, lsb_repeat_disable},
                {29'h0, cfg[k][0], cfg[k][1], cfg[k][2]}, "command bits");
            d = 32'h0;
            while (d[STAT_BUSY] !== 1'b0 || d[STAT_DONE] !== 1'b1)
                axi_read(REG_STATUS, d, RESP_OKAY);
            check(d, 32'h2, "status after frame");
            expect_rd(REG_RESULT, {20'h0, code[k]}, "result word");
            expect_rd(REG_ECHO, cfg[k][2] ? 32'h0 : {20'h0, code[k]}, "repeat word");
            check(32'(samp_cnt - s0), 32'(3 * HALF), "sampling span");
            axi_write(REG_STATUS, 32'h6, RESP_OKAY);
            expect_rd(REG_STATUS, 32'h0, "status cleared");
            $display("test frame %0d done", k);
        end
        axi_write(REG_RESULT, 32'h0, RESP_OKAY);
        expect_rd(REG_RESULT, 32'h001, "result kept");
        $display("test read-only result done");
        give_verdict();
    end
endmodule : adc_spi_byte_readout_bench

`default_nettype wire
